/* design/data_op_unit.sv */
// Data operation unit: compare, add and subtract on 16/32-bit operands.
// Assumes an APB master on clk_sys_i; no wait states are inserted.
//
// What this block does
// - Compare, add or subtract on operands of 16 or 32 bits by size bit.
// - Condition field bits 6:4; 000 detects mismatch, 001 detects match.
// - Code 010 detects input below reference low, 011 input above it.
// - Code 100 detects input strictly between reference low and high.
// - Code 101 detects input below reference low or above reference high.
// - Add flags overflow past FFFFh (16-bit) or FFFF FFFFh (32-bit).
// - Subtract flags underflow below zero at the selected width.
// - Interrupt raised on condition met, add overflow, subtract underflow.
// - Control bit 7 enables the interrupt; 0 disables it.
// - Event-link output pulses on the same three conditions.
// - Input and reference low are 32-bit RW; reference high bounds ranges.
// - Result flags sit in a status register cleared by a clear register.
// - Module stop state halts operation to save power.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

module data_op_unit (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // APB slave
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Interrupt and event link
    output logic irq_o,
    output data_op_unit_pkg::events_type event_o
);

    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == data_op_unit_pkg::OFS_CONTROL) ||
                    (addr == data_op_unit_pkg::OFS_OPERAND) ||
                    (addr == data_op_unit_pkg::OFS_REF_LOW) ||
                    (addr == data_op_unit_pkg::OFS_REF_HIGH) ||
                    (addr == data_op_unit_pkg::OFS_STATUS) ||
                    (addr == data_op_unit_pkg::OFS_STATUS_CLR) ||
                    (addr == data_op_unit_pkg::OFS_EVENT_EN) ||
                    (addr == data_op_unit_pkg::OFS_RESULT);
    endfunction

    // Byte-lane merge of write data into an old word
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        merge_bytes = res;
    endfunction

    // Start decode is shared so both sequencer states accept the same trigger
    function automatic logic starts_op(input logic wr, input logic [7:0] addr, input logic stop);
        starts_op = wr && (addr == data_op_unit_pkg::OFS_OPERAND) && !stop;
    endfunction

    data_op_unit_pkg::control_type control_r;
    data_op_unit_pkg::control_type control_nxt;
    logic [31:0] operand_r;
    logic [31:0] operand_nxt;
    logic [31:0] ref_low_r;
    logic [31:0] ref_low_nxt;
    logic [31:0] ref_high_r;
    logic [31:0] ref_high_nxt;
    logic [31:0] result_r;
    logic [31:0] result_nxt;
    logic [2:0] event_en_r;
    logic [2:0] event_en_nxt;
    logic [2:0] status_r;
    logic [2:0] status_nxt;
    data_op_unit_pkg::events_type event_r;
    data_op_unit_pkg::events_type event_nxt;
    data_op_unit_pkg::op_state_type state_r;
    data_op_unit_pkg::op_state_type state_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pslverr_r;
    logic pslverr_nxt;

    logic setup_phase;
    logic wr_access;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] opc;
    logic [32:0] sum;
    logic [32:0] diff;
    logic cond_met;
    logic add_ovf;
    logic sub_udf;
    data_op_unit_pkg::events_type found;
    logic [2:0] clear_mask;

    assign setup_phase = psel_i && !penable_i;
    // Unmapped writes are dropped here so a stray address cannot hit a register
    assign wr_access = psel_i && penable_i && pwrite_i && is_mapped(paddr_i);

    // Operands masked to the selected width; held at zero while stopped so
    // the adders and comparators do not toggle, at the cost of a mux level
    always_comb begin
        if (control_r.module_stop) begin
            opa = 32'h0000_0000;
            opb = 32'h0000_0000;
            opc = 32'h0000_0000;
        end else if (control_r.operand_size_select) begin
            opa = operand_r;
            opb = ref_low_r;
            opc = ref_high_r;
        end else begin
            opa = {16'h0000, operand_r[15:0]};
            opb = {16'h0000, ref_low_r[15:0]};
            opc = {16'h0000, ref_high_r[15:0]};
        end
    end

    assign sum = {1'b0, opa} + {1'b0, opb};
    assign diff = {1'b0, opa} - {1'b0, opb};

    // Carry out of the active width marks overflow
    assign add_ovf = control_r.operand_size_select ? sum[32] : sum[16];
    // Borrow means the difference went below zero
    assign sub_udf = opa < opb;

    always_comb begin
        case (control_r.detect_condition_select)
            data_op_unit_pkg::COND_MISMATCH: cond_met = opa != opb;
            data_op_unit_pkg::COND_MATCH: cond_met = opa == opb;
            data_op_unit_pkg::COND_LESS: cond_met = opa < opb;
            data_op_unit_pkg::COND_GREATER: cond_met = opa > opb;
            data_op_unit_pkg::COND_IN_RANGE: cond_met = (opa > opb) && (opa < opc);
            data_op_unit_pkg::COND_OUT_RANGE: cond_met = (opa < opb) || (opa > opc);
            // Prohibited codes detect nothing rather than guess
            default: cond_met = 1'b0;
        endcase
    end

    always_comb begin
        found = '0;
        case (data_op_unit_pkg::op_mode_type'(control_r.op_mode))
            data_op_unit_pkg::MODE_COMPARE: found.compare_met = cond_met;
            data_op_unit_pkg::MODE_ADD: found.overflow = add_ovf;
            data_op_unit_pkg::MODE_SUB: found.underflow = sub_udf;
            default: found = '0;
        endcase
    end

    // Sequencer: a write to the input arms one execution cycle
    always_comb begin
        state_nxt = data_op_unit_pkg::OP_IDLE;
        case (state_r)
            data_op_unit_pkg::OP_IDLE: begin
                if (starts_op(wr_access, paddr_i, control_r.module_stop)) begin
                    state_nxt = data_op_unit_pkg::OP_EXEC;
                end
            end
            data_op_unit_pkg::OP_EXEC: begin
                // A new write during execution chains another operation
                if (starts_op(wr_access, paddr_i, control_r.module_stop)) begin
                    state_nxt = data_op_unit_pkg::OP_EXEC;
                end
            end
            default: state_nxt = data_op_unit_pkg::OP_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_r <= data_op_unit_pkg::OP_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Register file writes and status clear decode
    always_comb begin
        control_nxt = control_r;
        operand_nxt = operand_r;
        ref_low_nxt = ref_low_r;
        ref_high_nxt = ref_high_r;
        event_en_nxt = event_en_r;
        clear_mask = 3'h0;
        if (wr_access) begin
            case (paddr_i)
                data_op_unit_pkg::OFS_CONTROL: begin
                    if (pstrb_i[0]) begin
                        control_nxt = pwdata_i[7:0];
                    end
                end
                data_op_unit_pkg::OFS_OPERAND:
                    operand_nxt = merge_bytes(operand_r, pwdata_i, pstrb_i);
                data_op_unit_pkg::OFS_REF_LOW:
                    ref_low_nxt = merge_bytes(ref_low_r, pwdata_i, pstrb_i);
                data_op_unit_pkg::OFS_REF_HIGH:
                    ref_high_nxt = merge_bytes(ref_high_r, pwdata_i, pstrb_i);
                data_op_unit_pkg::OFS_STATUS_CLR: begin
                    if (pstrb_i[0]) begin
                        clear_mask = pwdata_i[2:0];
                    end
                end
                data_op_unit_pkg::OFS_EVENT_EN: begin
                    if (pstrb_i[0]) begin
                        event_en_nxt = pwdata_i[2:0];
                    end
                end
                default: clear_mask = 3'h0;
            endcase
        end
    end

    // Configuration registers keep their value through module stop
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            control_r <= data_op_unit_pkg::CONTROL_RST;
            operand_r <= data_op_unit_pkg::DATA_RST;
            ref_low_r <= data_op_unit_pkg::DATA_RST;
            ref_high_r <= data_op_unit_pkg::DATA_RST;
            event_en_r <= data_op_unit_pkg::EVENT_EN_RST;
        end else begin
            control_r <= control_nxt;
            operand_r <= operand_nxt;
            ref_low_r <= ref_low_nxt;
            ref_high_r <= ref_high_nxt;
            event_en_r <= event_en_nxt;
        end
    end

    // Stop freezes the datapath; registers stay reachable
    always_comb begin
        result_nxt = result_r;
        if (state_r == data_op_unit_pkg::OP_EXEC && !control_r.module_stop) begin
            case (data_op_unit_pkg::op_mode_type'(control_r.op_mode))
                data_op_unit_pkg::MODE_ADD: begin
                    result_nxt = control_r.operand_size_select ? sum[31:0] :
                                 {16'h0000, sum[15:0]};
                end
                data_op_unit_pkg::MODE_SUB: begin
                    result_nxt = control_r.operand_size_select ? diff[31:0] :
                                 {16'h0000, diff[15:0]};
                end
                // Compare and the spare mode leave the last sum or difference
                default: result_nxt = result_r;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            result_r <= data_op_unit_pkg::DATA_RST;
        end else begin
            result_r <= result_nxt;
        end
    end

    // Sticky status: a new event wins over a clear in the same cycle
    always_comb begin
        event_nxt = '0;
        if (state_r == data_op_unit_pkg::OP_EXEC && !control_r.module_stop) begin
            event_nxt = found;
        end
    end

    // The link output is a one-cycle pulse, separate from the sticky copy
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            event_r <= '0;
        end else begin
            event_r <= event_nxt;
        end
    end

    // One sticky bit per event kind
    generate
        for (genvar g = 0; g < 3; g++) begin : g_status
            always_comb begin
                status_nxt[g] = (status_r[g] && !clear_mask[g]) || event_nxt[g];
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            status_r <= 3'h0;
        end else begin
            status_r <= status_nxt;
        end
    end

    // Read data is latched in the setup phase so prdata comes from a flop
    always_comb begin
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        if (setup_phase) begin
            pslverr_nxt = !is_mapped(paddr_i);
            prdata_nxt = 32'h0000_0000;
            if (!pwrite_i) begin
                case (paddr_i)
                    data_op_unit_pkg::OFS_CONTROL: prdata_nxt = {24'h000000, control_r};
                    data_op_unit_pkg::OFS_OPERAND: prdata_nxt = operand_r;
                    data_op_unit_pkg::OFS_REF_LOW: prdata_nxt = ref_low_r;
                    data_op_unit_pkg::OFS_REF_HIGH: prdata_nxt = ref_high_r;
                    data_op_unit_pkg::OFS_STATUS: prdata_nxt = {29'h0, status_r};
                    data_op_unit_pkg::OFS_EVENT_EN: prdata_nxt = {29'h0, event_en_r};
                    data_op_unit_pkg::OFS_RESULT: prdata_nxt = result_r;
                    default: prdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata_o = prdata_r;
    assign pready_o = 1'b1;
    // Error shows only in the access phase, where the master samples it
    assign pslverr_o = pslverr_r && psel_i && penable_i;
    assign event_o = event_r;
    // Per-event enable, then the global control enable
    assign irq_o = control_r.result_irq_enable && |(status_r & event_en_r);

endmodule

/* include/data_op_unit_pkg.sv */
// Constants, field layouts and types for the data operation unit.
// Assumes an APB slave with 32-bit data and byte addresses.
package data_op_unit_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_OPERAND = 8'h04;
    localparam logic [7:0] OFS_REF_LOW = 8'h08;
    localparam logic [7:0] OFS_REF_HIGH = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_STATUS_CLR = 8'h14;
    localparam logic [7:0] OFS_EVENT_EN = 8'h18;
    localparam logic [7:0] OFS_RESULT = 8'h1c;

    // Reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic [2:0] EVENT_EN_RST = 3'h0;

    // Operation modes
    typedef enum logic [1:0] {
        MODE_COMPARE = 2'b00,
        MODE_ADD = 2'b01,
        MODE_SUB = 2'b10,
        MODE_NONE = 2'b11
    } op_mode_type;

    // Detection conditions
    typedef enum logic [2:0] {
        COND_MISMATCH = 3'b000,
        COND_MATCH = 3'b001,
        COND_LESS = 3'b010,
        COND_GREATER = 3'b011,
        COND_IN_RANGE = 3'b100,
        COND_OUT_RANGE = 3'b101
    } cond_type;

    // Control layout: b7 irq enable, b6:4 condition, b3 size, b2 stop, b1:0 mode
    typedef struct packed {
        logic result_irq_enable;
        logic [2:0] detect_condition_select;
        logic operand_size_select;
        logic module_stop;
        logic [1:0] op_mode;
    } control_type;

    // Status layout: b2 underflow, b1 overflow, b0 compare condition met
    typedef struct packed {
        logic underflow;
        logic overflow;
        logic compare_met;
    } events_type;

    // Sequencer states
    typedef enum logic {
        OP_IDLE = 1'b0,
        OP_EXEC = 1'b1
    } op_state_type;

endpackage

/* verification/data_op_unit_asserts.sv */
// Concurrent checks on the data operation unit top-level ports.
// Assumes binding to data_op_unit; the control byte is shadowed from APB writes.
`timescale 1ns/1ps
module data_op_unit_asserts (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // APB slave
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Interrupt and event link
    input wire logic irq_o,
    input wire data_op_unit_pkg::events_type event_o
);
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic wr_acc;
    logic clr_wr;
    assign wr_acc = psel_i && penable_i && pwrite_i;
    // Any of these writes may legally drop the interrupt
    assign clr_wr = wr_acc && (paddr_i == data_op_unit_pkg::OFS_STATUS_CLR
        || paddr_i == data_op_unit_pkg::OFS_CONTROL || paddr_i == data_op_unit_pkg::OFS_EVENT_EN);
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_acc && paddr_i == data_op_unit_pkg::OFS_CONTROL && pstrb_i[0]) begin
            ctrl_nxt = pwdata_i[7:0];
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ctrl_r <= data_op_unit_pkg::CONTROL_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    sequence s_op_write;
        wr_acc && paddr_i == data_op_unit_pkg::OFS_OPERAND;
    endsequence
    sequence s_pulse;
        event_o != 3'b000 ##1 event_o == 3'b000;
    endsequence
    a_ready_always: assert property (pready_o)
        else $error("pready low");
    a_error_unmapped: assert property (psel_i && penable_i && paddr_i[1:0] == 2'b00 |->
        pslverr_o == (paddr_i >= 8'h20)) else $error("slave error wrong");
    a_event_single: assert property (event_o != 3'b000 |-> s_pulse)
        else $error("event longer than one cycle");
    a_event_cause: assert property (event_o != 3'b000 |->
        $past(wr_acc && paddr_i == data_op_unit_pkg::OFS_OPERAND && !ctrl_r[2], 2))
        else $error("event without operand write");
    a_stop_quiet: assert property (s_op_write ##0 ctrl_r[2] |-> ##2 event_o == 3'b000)
        else $error("event while stopped");
    a_add_mode: assert property (event_o.overflow |-> $past(ctrl_r[1:0], 2) == 2'b01)
        else $error("overflow outside add");
    a_sub_mode: assert property (event_o.underflow |-> $past(ctrl_r[1:0], 2) == 2'b10)
        else $error("underflow outside subtract");
    a_cmp_mode: assert property (event_o.compare_met |-> $past(ctrl_r[1:0], 2) == 2'b00
        && $past(ctrl_r[6:4], 2) < 3'd6) else $error("compare event in wrong setting");
    a_irq_gated: assert property (!ctrl_r[7] |-> !irq_o)
        else $error("interrupt while disabled");
    a_irq_hold: assert property ($fell(irq_o) |-> $past(clr_wr))
        else $error("interrupt dropped without clear");
endmodule

bind data_op_unit data_op_unit_asserts u_asserts (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .irq_o(irq_o), .event_o(event_o));

/* verification/data_op_unit_tb_top.sv */
// Self-checking bench for the data operation unit, driven over APB.
// Assumes the package is compiled first and the checker is bound to the design.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module data_op_unit_tb_top;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] paddr_i = 8'h00;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic irq_o;
    data_op_unit_pkg::events_type event_o;
    logic [31:0] rd_q;
    logic rd_e;
    logic [2:0] evt_en = 3'h0;
    int bad_count = 0;
    int n_checks = 0;
    logic [31:0] opnd [6] = '{32'd100, 32'd50, 32'd150, 32'd250, 32'd200, 32'h0001_0064};
    // Add and subtract cases: control, operand, reference, events, masked result
    logic [7:0] ac [7] = '{8'h81, 8'h81, 8'h89, 8'h89, 8'h82, 8'h8a, 8'h8a};
    logic [31:0] ax [7] = '{32'hffff, 32'hfffe, 32'hffff_ffff, 32'hffff, 32'h0, 32'h5, 32'h0};
    logic [31:0] ar [7] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h1, 32'h5, 32'h1};
    logic [2:0] ae [7] = '{3'h2, 3'h0, 3'h2, 3'h0, 3'h4, 3'h0, 3'h4};
    logic [31:0] ay [7] = '{32'h0, 32'hffff, 32'h0, 32'h1_0000, 32'hffff, 32'h0, 32'hffff_ffff};

    data_op_unit dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
        .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .irq_o(irq_o), .event_o(event_o));

    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Read data and error are taken at the edge that closes the access phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (pready_o !== 1'b1) begin
            bad_count++;
            report_and_stop;
        end
        rd_q = prdata_o;
        rd_e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    function automatic logic hit(input logic [2:0] c, input logic sz, input logic [31:0] x,
        input logic [31:0] lo, input logic [31:0] hi);
        logic [31:0] m;
        m = sz ? 32'hffff_ffff : 32'h0000_ffff;
        x &= m;
        lo &= m;
        hi &= m;
        case (c)
            3'd0: return x != lo;
            3'd1: return x == lo;
            3'd2: return x < lo;
            3'd3: return x > lo;
            3'd4: return x > lo && x < hi;
            3'd5: return x < lo || x > hi;
            default: return 1'b0;
        endcase
    endfunction

    // Flags show two edges after the operand write and stay until cleared
    task automatic run_op(input logic [7:0] c, input logic [31:0] x, input logic [2:0] e);
        xfer(1'b1, data_op_unit_pkg::OFS_CONTROL, {24'h000000, c});
        xfer(1'b1, data_op_unit_pkg::OFS_OPERAND, x);
        repeat (2) @(posedge clk_sys_i);
        `CHK(event_o, e)
        xfer(1'b0, data_op_unit_pkg::OFS_STATUS, 32'h0);
        `CHK(rd_q[2:0], e)
        `CHK(irq_o, c[7] && (e & evt_en) != 3'h0)
        xfer(1'b1, data_op_unit_pkg::OFS_STATUS_CLR, 32'h7);
        @(posedge clk_sys_i);
        `CHK(irq_o, 1'b0)
    endtask

    initial begin
        repeat (6) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            xfer(1'b0, 8'(i * 4), 32'h0);
            `CHK(rd_q, 32'h0)
        end
        $display("Test reset values done");
        for (int i = 1; i < 4; i++) begin
            xfer(1'b1, 8'(i * 4), {8'(i), 24'h5ac3e1});
            xfer(1'b0, 8'(i * 4), 32'h0);
            `CHK(rd_q, {8'(i), 24'h5ac3e1})
        end
        xfer(1'b1, data_op_unit_pkg::OFS_STATUS_CLR, 32'h7);
        xfer(1'b1, data_op_unit_pkg::OFS_STATUS, 32'h7);
        xfer(1'b0, data_op_unit_pkg::OFS_STATUS, 32'h0);
        `CHK(rd_q, 32'h0)
        xfer(1'b0, 8'h20, 32'h0);
        `CHK(rd_e, 1'b1)
        `CHK(rd_q, 32'h0)
        evt_en = 3'h7;
        xfer(1'b1, data_op_unit_pkg::OFS_EVENT_EN, {29'h0, evt_en});
        $display("Test register access done");
        xfer(1'b1, data_op_unit_pkg::OFS_REF_LOW, 32'd100);
        xfer(1'b1, data_op_unit_pkg::OFS_REF_HIGH, 32'd200);
        for (int sz = 0; sz < 2; sz++) begin
            for (int c = 0; c < 6; c++) begin
                for (int k = 0; k < 6; k++) begin
                    run_op({1'(k), 3'(c), 1'(sz), 3'b000}, opnd[k],
                        {2'b00, hit(3'(c), 1'(sz), opnd[k], 32'd100, 32'd200)});
                end
            end
        end
        $display("Test compare done");
        for (int i = 0; i < 7; i++) begin
            xfer(1'b1, data_op_unit_pkg::OFS_REF_LOW, ar[i]);
            run_op(ac[i], ax[i], ae[i]);
            xfer(1'b0, data_op_unit_pkg::OFS_RESULT, 32'h0);
            `CHK(rd_q, ay[i])
        end
        $display("Test add and subtract done");
        run_op(8'h8d, 32'hffff_ffff, 3'h0);
        xfer(1'b0, data_op_unit_pkg::OFS_RESULT, 32'h0);
        `CHK(rd_q, ay[6])
        run_op(8'h8b, 32'hffff_ffff, 3'h0);
        xfer(1'b0, data_op_unit_pkg::OFS_RESULT, 32'h0);
        `CHK(rd_q, ay[6])
        evt_en = 3'h1;
        xfer(1'b1, data_op_unit_pkg::OFS_EVENT_EN, {29'h0, evt_en});
        run_op(8'h89, 32'hffff_ffff, 3'h2);
        $display("Test stop and masking done");
        report_and_stop;
    end

    initial begin
        repeat (100000) @(posedge clk_sys_i);
        bad_count++;
        report_and_stop;
    end
endmodule
